// *** design/hpc_bank.sv ***
// Period report and general configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.svh"
module hpc_bank #(
	parameter int PERIOD_W = 10
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Register port from the serial target engine.
	input wire hpc_pkg::hpc_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	// Target address check.
	input wire logic [6:0] target_addr_i,
	output logic shared_addr_match_o,
	// Measurement and engine status.
	input wire logic [PERIOD_W-1:0] period_sample_i,
	input wire logic period_valid_i,
	input wire logic playback_active_i,
	input wire logic [4:0] status_src_i,
	input wire logic go_write_i,
	input wire logic go_value_i,
	// Trigger or interrupt pin.
	input wire logic trigger_or_irq_pin_i,
	output logic trigger_or_irq_pin_o,
	output logic trigger_or_irq_pin_oe_o,
	// Engine controls.
	output hpc_pkg::hpc_ctrl_t ctrl_o,
	output hpc_pkg::hpc_mode_t mode_o,
	output logic [2:0] line_regulation_comp_pct_o,
	output logic [24:0] resonance_period_ns_o
);
	import hpc_pkg::*;

	if (PERIOD_W != 10) begin
		$error("hpc_bank serves a 10-bit period only");
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [9:0] avg4(input logic [9:0] a, input logic [29:0] h);
		logic [11:0] s;
		s = 12'(a) + 12'(h[9:0]) + 12'(h[19:10]) + 12'(h[29:20]);
		return s[11:2];
	endfunction

	function automatic logic [2:0] comp_pct(input logic [1:0] code);
		logic [2:0] p;
		unique case (code)
			2'd0: p = 3'd0;
			2'd1: p = 3'd2;
			2'd2: p = 3'd4;
			2'd3: p = 3'd5;
		endcase
		return p;
	endfunction

	// ****************************************
	// State
	// ****************************************
	hpc_state_t st;
	hpc_state_t next_st;
	hpc_pin_func_t pin_func;
	hpc_pin_func_t wr_pin_func;
	logic cfg_wr;
	logic pin_rise;
	logic pin_fall;

	assign pin_func = hpc_pin_func_t'(st.cfg[`HPC_CFG_PIN_LSB +: 2]);
	assign wr_pin_func = hpc_pin_func_t'(reg_req_i.wdata[`HPC_CFG_PIN_LSB +: 2]);
	assign cfg_wr = reg_req_i.wr && ({1'b0, reg_req_i.addr} == `HPC_ADDR_CONFIG);
	assign pin_rise = (st.pin_sync[1] == st.pin_sync[2]) && st.pin_sync[2] && !st.pin_level;
	assign pin_fall = (st.pin_sync[1] == st.pin_sync[2]) && !st.pin_sync[2] && st.pin_level;

	always_comb begin
		next_st = st;
		next_st.ctrl = '0;
		next_st.active_d = playback_active_i;
		next_st.pin_sync = {st.pin_sync[1:0], trigger_or_irq_pin_i};
		if (st.pin_sync[1] == st.pin_sync[2]) begin
			next_st.pin_level = st.pin_sync[2];
		end
		// Measurement path.
		if (period_valid_i && playback_active_i) begin
			next_st.hist = {st.hist[19:0], period_sample_i};
			if (!st.lock) begin
				if (st.cfg[`HPC_CFG_AVG_OFF_BIT]) begin
					next_st.report = period_sample_i;
				end else begin
					next_st.report = avg4(period_sample_i, st.hist);
				end
			end
		end
		next_st.period_ns = 25'(st.report * `HPC_PERIOD_STEP_NS);
		// Playback end releases the freeze; a high read in the same cycle sets it again.
		if (st.active_d && !playback_active_i) begin
			next_st.lock = 1'b0;
		end
		// Register reads, with the read lock side effects.
		if (reg_req_i.rd) begin
			unique case ({1'b0, reg_req_i.addr})
				`HPC_ADDR_IRQ_MASK: next_st.rdata = {3'h0, st.mask};
				`HPC_ADDR_PERIOD_HIGH: begin
					next_st.rdata = {6'h00, st.report[9:8]};
					next_st.lock = 1'b1;
				end
				`HPC_ADDR_PERIOD_LOW: begin
					next_st.rdata = st.report[7:0];
					next_st.lock = 1'b0;
				end
				`HPC_ADDR_CONFIG: next_st.rdata = st.cfg;
				default: next_st.rdata = 8'h00;
			endcase
		end
		// Register writes; the low period byte takes none.
		if (reg_req_i.wr && ({1'b0, reg_req_i.addr} == `HPC_ADDR_IRQ_MASK)) begin
			next_st.mask = reg_req_i.wdata[4:0];
		end
		if (cfg_wr) begin
			next_st.cfg = reg_req_i.wdata;
			if (playback_active_i && ((wr_pin_func != pin_func)
				|| (reg_req_i.wdata[1:0] != st.cfg[1:0]))) begin
				next_st.ctrl.standby = 1'b1;
			end
		end
		// Start and cancel sources by pin function.
		if (!next_st.ctrl.standby) begin
			unique case (pin_func)
				HPC_PIN_PULSE: begin
					next_st.ctrl.process_start = pin_rise || (go_write_i && go_value_i);
					next_st.ctrl.process_cancel = go_write_i && !go_value_i;
				end
				HPC_PIN_LEVEL: begin
					next_st.ctrl.process_start = pin_rise;
					next_st.ctrl.process_cancel = pin_fall;
				end
				HPC_PIN_IRQ: begin
					next_st.ctrl.process_start = go_write_i && go_value_i;
					next_st.ctrl.process_cancel = go_write_i && !go_value_i;
				end
				HPC_PIN_RSVD: begin
					next_st.ctrl.process_start = 1'b0;
				end
			endcase
		end
		next_st.irq = (pin_func == HPC_PIN_IRQ) && |(status_src_i & ~st.mask);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.cfg <= `HPC_RESET_CONFIG;
			st.mask <= `HPC_RESET_IRQ_MASK;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata_o = st.rdata;
	assign shared_addr_match_o = st.cfg[`HPC_CFG_SHARED_EN_BIT] && (target_addr_i == `HPC_SHARED_TARGET_ADDR);
	assign trigger_or_irq_pin_o = 1'b0;
	assign trigger_or_irq_pin_oe_o = st.irq;
	assign ctrl_o = st.ctrl;
	assign mode_o = hpc_mode_t'(st.cfg[`HPC_CFG_MODE_LSB +: 2]);
	assign line_regulation_comp_pct_o = comp_pct(st.cfg[`HPC_CFG_COMP_LSB +: 2]);
	assign resonance_period_ns_o = st.period_ns;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_high_read;
		reg_req_i.rd && ({1'b0, reg_req_i.addr} == `HPC_ADDR_PERIOD_HIGH);
	endsequence
	sequence s_frozen;
		st.lock && !(reg_req_i.rd && ({1'b0, reg_req_i.addr} == `HPC_ADDR_PERIOD_LOW)) && !(st.active_d && !playback_active_i);
	endsequence

	property p_lock_on_high;
		@(posedge sys_clk_i) disable iff (!rst_n_i) s_high_read |=> st.lock;
	endproperty
	a_lock_on_high: assert property (p_lock_on_high) else $error("high read did not freeze");

	property p_frozen_holds;
		@(posedge sys_clk_i) disable iff (!rst_n_i) s_frozen |=> $stable(st.report);
	endproperty
	a_frozen_holds: assert property (p_frozen_holds) else $error("frozen report changed");

	property p_release_on_end;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			(st.active_d && !playback_active_i
			&& !(reg_req_i.rd && ({1'b0, reg_req_i.addr} == `HPC_ADDR_PERIOD_HIGH))) |=> !st.lock;
	endproperty
	a_release_on_end: assert property (p_release_on_end) else $error("lock kept after playback end");

	property p_latest_sample;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			(period_valid_i && playback_active_i && !st.lock && st.cfg[6]) |=> st.report == $past(period_sample_i);
	endproperty
	a_latest_sample: assert property (p_latest_sample) else $error("report is not latest sample");

	property p_scale;
		@(posedge sys_clk_i) disable iff (!rst_n_i) ##1 resonance_period_ns_o == 25'($past(st.report) * 24390);
	endproperty
	a_scale: assert property (p_scale) else $error("period scaling wrong");

	property p_shared_addr;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			shared_addr_match_o |-> (target_addr_i == 7'h58) && st.cfg[7];
	endproperty
	a_shared_addr: assert property (p_shared_addr) else $error("shared address answered wrongly");

	property p_mode_abort;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			(cfg_wr && playback_active_i && reg_req_i.wdata[1:0] != st.cfg[1:0]) |=> ctrl_o.standby && !ctrl_o.process_start;
	endproperty
	a_mode_abort: assert property (p_mode_abort) else $error("mode change did not stop process");

	property p_pin_abort;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			(cfg_wr && playback_active_i && wr_pin_func != pin_func) |=> ctrl_o.standby;
	endproperty
	a_pin_abort: assert property (p_pin_abort) else $error("pin function change did not stop process");

	property p_level_ignores_go;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			(pin_func == HPC_PIN_LEVEL && !cfg_wr && !pin_rise && !pin_fall) |=> !ctrl_o.process_start && !ctrl_o.process_cancel;
	endproperty
	a_level_ignores_go: assert property (p_level_ignores_go) else $error("go acted in level mode");

	property p_irq_gate;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			trigger_or_irq_pin_oe_o |-> $past(pin_func) == HPC_PIN_IRQ && |($past(status_src_i) & ~$past(st.mask));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt pin driven without cause");

	property p_low_write_ignored;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
			(reg_req_i.wr && reg_req_i.addr == 7'h06 && !(period_valid_i && playback_active_i)) |=> $stable(st.report);
	endproperty
	a_low_write_ignored: assert property (p_low_write_ignored) else $error("low byte write changed report");
endmodule
`default_nettype wire

// *** design/hpc_regs.svh ***
// Register offsets, field positions, reset values and timing constants of the period and mode bank.
// Behaviour
// - Period report updates continuously during playback
// - Upper read first freezes both until low
// - Playback end releases freeze, updates resume
// - Period equals count times fixed step
// - Shared target address answered when enabled
// - Averaging over four when bit cleared
// - Compensation code selects 0,2,4,5 percent
// - Pulse trigger mode: pin and go start
// - Level trigger mode: pin enables, go ignored
// - Interrupt mode: open drain, go only
// - Pin function change mid-process forces standby
// - Mode field selects one of four processes
// - Mode change mid-process stops at once
// - Upper period bits sit below low byte
// - Unmasked status sources drive interrupt pin
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
`define HPC_ADDR_IRQ_MASK 8'h02
`define HPC_ADDR_PERIOD_HIGH 8'h05
`define HPC_ADDR_PERIOD_LOW 8'h06
`define HPC_ADDR_CONFIG 8'h07
`define HPC_CFG_SHARED_EN_BIT 7
`define HPC_CFG_AVG_OFF_BIT 6
`define HPC_CFG_COMP_LSB 4
`define HPC_CFG_PIN_LSB 2
`define HPC_CFG_MODE_LSB 0
`define HPC_RESET_CONFIG 8'h54
`define HPC_RESET_IRQ_MASK 5'h18
`define HPC_SHARED_TARGET_ADDR 7'h58
`define HPC_PERIOD_STEP_NS 24390
`define HPC_AVG_DEPTH 4
`endif

// *** design/hpc_pkg.sv ***
// Types of the period and mode bank.
package hpc_pkg;
	typedef enum logic [1:0] {HPC_PIN_PULSE, HPC_PIN_LEVEL, HPC_PIN_IRQ, HPC_PIN_RSVD} hpc_pin_func_t;
	typedef enum logic [1:0] {HPC_MODE_REALTIME, HPC_MODE_SEQUENCER, HPC_MODE_DIAG, HPC_MODE_CALIB} hpc_mode_t;
	typedef struct packed {
		logic [6:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} hpc_reg_req_t;
	typedef struct packed {
		logic process_start;
		logic process_cancel;
		logic standby;
	} hpc_ctrl_t;
	typedef struct packed {
		logic [7:0] cfg;
		logic [4:0] mask;
		logic lock;
		logic [9:0] report;
		logic [29:0] hist;
		logic active_d;
		logic [2:0] pin_sync;
		logic pin_level;
		hpc_ctrl_t ctrl;
		logic [7:0] rdata;
		logic [24:0] period_ns;
		logic irq;
	} hpc_state_t;
endpackage

// *** test/hpc_host_model.sv ***
// Host model that drives the register port of the period and mode bank.
`timescale 1ns/1ps
`default_nettype none
module hpc_host_model (
	// Clock and read data.
	input wire logic sys_clk_i,
	input wire logic [7:0] reg_rdata_i,
	// Register requests.
	output hpc_pkg::hpc_reg_req_t reg_req_o
);
	import hpc_pkg::*;
	initial reg_req_o = '0;
	// One request cycle; afterwards address and data show inverted values and rd and wr drop low.
	task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(negedge sys_clk_i);
		reg_req_o <= '{addr: a, rd: !w, wr: w, wdata: d};
		@(negedge sys_clk_i);
		reg_req_o <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
		@(negedge sys_clk_i);
		q = reg_rdata_i;
	endtask
	// Upper period bits are read before the low byte.
	task automatic rd_period(output logic [9:0] p);
		logic [7:0] h;
		logic [7:0] l;
		xfer(7'h05, 1'b0, 8'h00, h);
		xfer(7'h06, 1'b0, 8'h00, l);
		p = {h[1:0], l};
	endtask
endmodule
`default_nettype wire

// *** test/test_haptic_period_and_mode_config.sv ***
// Self-checking testbench of the period and mode bank.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_regs.svh"
module test_haptic_period_and_mode_config;
	import hpc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	hpc_reg_req_t req;
	logic [7:0] rdata, q;
	logic [6:0] taddr = 7'h00;
	logic match, valid = 1'b0, play = 1'b0, gow = 1'b0, gov = 1'b0, pin = 1'b0, pin_o, pin_oe;
	logic [9:0] sample = 10'h000, p;
	logic [4:0] status = 5'h00;
	hpc_ctrl_t ctrl;
	hpc_mode_t mode;
	logic [2:0] pct;
	logic [24:0] pns;
	wire logic pin_w;
	int err_total = 0, n_checks = 0, n_start = 0, n_cancel = 0, n_stb = 0, cycles = 0;
	logic [2:0] pct_tab [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
	// Open-drain pin: pulled low while the bank drives it.
	assign pin_w = (pin_oe === 1'b1) ? 1'b0 : pin;
	always #4 sys_clk_i = ~sys_clk_i;
	hpc_host_model i_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_req_o(req));
	hpc_bank i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.target_addr_i(taddr), .shared_addr_match_o(match), .period_sample_i(sample),
		.period_valid_i(valid), .playback_active_i(play), .status_src_i(status), .go_write_i(gow),
		.go_value_i(gov), .trigger_or_irq_pin_i(pin_w), .trigger_or_irq_pin_o(pin_o),
		.trigger_or_irq_pin_oe_o(pin_oe), .ctrl_o(ctrl), .mode_o(mode),
		.line_regulation_comp_pct_o(pct), .resonance_period_ns_o(pns));
	always @(posedge sys_clk_i) begin
		n_start += (ctrl.process_start === 1'b1);
		n_cancel += (ctrl.process_cancel === 1'b1);
		n_stb += (ctrl.standby === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out;
		if (err_total == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [24:0] got, input logic [24:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic rst;
		rst_n_i = 1'b0;
		cyc(3);
		rst_n_i = 1'b1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host.xfer(a, 1'b1, d, q);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		i_host.xfer(a, 1'b0, 8'h00, q);
		chk(q, e);
	endtask
	task automatic smp(input logic [9:0] v);
		@(negedge sys_clk_i);
		sample = v;
		valid = 1'b1;
		@(negedge sys_clk_i);
		valid = 1'b0;
	endtask
	task automatic go(input logic v);
		@(negedge sys_clk_i);
		gow = 1'b1;
		gov = v;
		@(negedge sys_clk_i);
		gow = 1'b0;
	endtask
	initial begin
		rst();
		rdc(7'h07, `HPC_RESET_CONFIG);
		chk(pct, 3'h2);
		wr(7'h06, 8'hff);
		wr(7'h1f, 8'hff);
		rdc(7'h06, 8'h00);
		rdc(7'h1f, 8'h00);
		play = 1'b1;
		smp(10'h2a5);
		cyc(2);
		chk(pns, 25'(10'h2a5 * `HPC_PERIOD_STEP_NS));
		rdc(7'h05, 8'h02);
		smp(10'h111);
		rdc(7'h06, 8'ha5);
		smp(10'h111);
		i_host.rd_period(p);
		chk(p, 10'h111);
		rdc(7'h05, 8'h01);
		play = 1'b0;
		cyc(2);
		play = 1'b1;
		smp(10'h0ff);
		rdc(7'h06, 8'hff);
		play = 1'b0;
		rst();
		play = 1'b1;
		wr(7'h07, 8'h14);
		smp(10'h100);
		smp(10'h200);
		i_host.rd_period(p);
		chk(p, 10'h0c0);
		play = 1'b0;
		for (int c = 0; c < 4; c++) begin
			wr(7'h07, {2'h1, c[1:0], 2'h1, c[1:0]});
			chk(pct, pct_tab[c]);
			chk(mode, c[1:0]);
		end
		taddr = 7'h58;
		wr(7'h07, 8'hd4);
		chk(match, 1'h1);
		taddr = 7'h59;
		cyc(1);
		chk(match, 1'h0);
		wr(7'h07, 8'h54);
		taddr = 7'h58;
		cyc(1);
		chk(match, 1'h0);
		wr(7'h07, 8'h50);
		n_start = 0;
		go(1'b1);
		cyc(2);
		chk(n_start, 25'h1);
		pin = 1'b1;
		cyc(8);
		chk(n_start, 25'h2);
		pin = 1'b0;
		cyc(8);
		n_cancel = 0;
		go(1'b0);
		cyc(2);
		chk(n_cancel, 25'h1);
		wr(7'h07, 8'h54);
		n_start = 0;
		go(1'b1);
		cyc(2);
		chk(n_start, 25'h0);
		pin = 1'b1;
		cyc(8);
		chk(n_start, 25'h1);
		n_cancel = 0;
		go(1'b0);
		cyc(2);
		chk(n_cancel, 25'h0);
		pin = 1'b0;
		cyc(8);
		chk(n_cancel, 25'h1);
		wr(7'h07, 8'h58);
		n_start = 0;
		go(1'b1);
		cyc(2);
		chk(n_start, 25'h1);
		pin = 1'b1;
		cyc(8);
		chk(n_start, 25'h1);
		pin = 1'b0;
		cyc(8);
		n_cancel = 0;
		go(1'b0);
		cyc(2);
		chk(n_cancel, 25'h1);
		status = 5'h08;
		cyc(4);
		chk(pin_oe, 1'h0);
		status = 5'h01;
		cyc(4);
		chk(pin_oe, 1'h1);
		chk(pin_o, 1'h0);
		wr(7'h02, 8'h1f);
		cyc(2);
		chk(pin_oe, 1'h0);
		status = 5'h00;
		play = 1'b1;
		n_stb = 0;
		wr(7'h07, 8'h59);
		chk(n_stb, 25'h1);
		wr(7'h07, 8'h55);
		chk(n_stb, 25'h2);
		wr(7'h07, 8'hd5);
		chk(n_stb, 25'h2);
		play = 1'b0;
		cyc(2);
		close_out();
	end
endmodule
`default_nettype wire
